// ---- verilog/jtid_defines.svh ----
// Constants for the test port instruction decode block
`ifndef JTID_DEFINES_SVH
`define JTID_DEFINES_SVH

// Instruction register width and capture pattern
`define JTID_IR_W          4
`define JTID_IR_CAPTURE    4'h1

// Instruction codes
`define JTID_INS_SAMPLE    4'h1
`define JTID_INS_IDCODE    4'h2
`define JTID_INS_EXTEST    4'h3
`define JTID_INS_HIGHZ     4'h4
`define JTID_INS_ISCAN     4'h7
`define JTID_INS_CMD       4'h8
`define JTID_INS_BYPASS    4'hF

// Identification word, value arbitrary, bit 0 set as the standard asks
`define JTID_ID_W          32
`define JTID_ID_VALUE      32'h1234_5671

// Command register width, user command codes and reset value
`define JTID_CMD_W         8
`define JTID_CMD_CLEAR     8'h01
`define JTID_CMD_REMAP     8'h02
`define JTID_CMD_RESET     8'h00

// System clock edges after a system reset before the synced clear toggle is trusted
`define JTID_SYNC_SETTLE   3'h5

`endif

// ---- verilog/jtid_pkg.sv ----
// Types for the test port instruction decode block
`default_nettype none
package jtid_pkg;

  // Data register that sits between the serial input and output, one-hot
  typedef enum logic [4:0] {
    JTID_SEL_BYPASS = 5'b0_0001,
    JTID_SEL_IDCODE = 5'b0_0010,
    JTID_SEL_BSR    = 5'b0_0100,
    JTID_SEL_ISCAN  = 5'b0_1000,
    JTID_SEL_CMD    = 5'b1_0000
  } jtid_sel_type;

endpackage
`default_nettype wire

// ---- verilog/jtid_sync.sv ----
// Three-stage level synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module jtid_sync (
  // Clock and reset of the receiving domain
  input  wire logic clk,
  input  wire logic rst,
  // Level from another domain and its filtered copy
  input  wire logic din,
  output var  logic dout
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic dout_ff;

  // Chain; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Output follows once the second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      dout_ff <= s3_ff;
    end
  end

  assign dout = dout_ff;

endmodule // jtid_sync
`default_nettype wire

// ---- verilog/jtid_cmd_reg.sv ----
// Vendor command shift register with latched parallel output
`timescale 1ns/10ps
`default_nettype none
`include "jtid_defines.svh"
module jtid_cmd_reg (
  // Test clock and port reset
  input  wire logic                   tck,
  input  wire logic                   tap_reset,
  // Serial data and state strobes
  input  wire logic                   tdi,
  input  wire logic                   selected,
  input  wire logic                   capture_dr,
  input  wire logic                   shift_dr,
  input  wire logic                   update_dr,
  // Serial output and latched command
  output var  logic                   shift_out,
  output var  logic [`JTID_CMD_W-1:0] cmd,
  output var  logic                   cmd_strobe
);

  logic [`JTID_CMD_W-1:0] shift_ff;
  logic [`JTID_CMD_W-1:0] cmd_ff;
  logic                   strobe_ff;

  // Shift stages; capture reloads the last latched command for readback
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      shift_ff <= `JTID_CMD_RESET;
    end else if (selected && capture_dr) begin
      shift_ff <= cmd_ff;
    end else if (selected && shift_dr) begin
      shift_ff <= {tdi, shift_ff[`JTID_CMD_W-1:1]};
    end
  end

  // Parallel latch hides shifting patterns from the decoder
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      cmd_ff    <= `JTID_CMD_RESET;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= selected && update_dr; // RQ20
      if (selected && update_dr) begin
        cmd_ff <= shift_ff; // RQ18
      end
    end
  end

  assign shift_out  = shift_ff[0];
  assign cmd        = cmd_ff;
  assign cmd_strobe = strobe_ff;

endmodule // jtid_cmd_reg
`default_nettype wire

// ---- verilog/jtid_instruction_decode.sv ----
// Test port instruction decode and data register selection
// Functional notes
// (RQ1) EXTEST taking effect drives output boundary cells onto pins at once.
// (RQ2) SAMPLE/PRELOAD shifts the boundary chain while system logic keeps the pins.
// (RQ3) Without preload, EXTEST pins stay undefined until the first scan ends.
// (RQ4) Code 03h selects EXTEST; output cells apply stimulus to the board.
// (RQ5) Under EXTEST input cells capture pin levels for shifting out.
// (RQ6) Tester preloads output latches before choosing EXTEST.
// (RQ7) Code 02h selects the 32-bit identification word for Shift-DR.
// (RQ8) Code 04h places every system output in a non-driving state.
// (RQ9) Under HIGHZ the one-stage bypass is the serial path.
// (RQ10) Code 07h selects the internal scan register as serial path.
// (RQ11) Code 08h selects the 8-bit command shift register as serial path.
// (RQ12) Command register decodes 256 codes; only two are for users.
// (RQ13) Command 01h clears the device like the master clear pin.
// (RQ14) That clear leaves the test port, its instruction and registers alone.
// (RQ15) Code 0Fh selects the one-stage bypass path.
// (RQ16) Code 01h snapshots pin values at Capture-DR on the rising edge.
// (RQ17) Command 02h remaps the test pins to the two-wire programming use.
// (RQ18) Command output is latched so shifting never reaches the decoder.
// (RQ19) Reserved command codes do nothing.
// (RQ20) Latched command acts at Update-DR while the command register is selected; here it acts on the tck edge after Update-DR.
`timescale 1ns/10ps
`default_nettype none
`include "jtid_defines.svh"
module jtid_instruction_decode
  import jtid_pkg::*;
(
  // System clock domain
  input  wire logic sys_clk,
  input  wire logic rst,
  // Test clock domain and its own port reset
  input  wire logic tck,
  input  wire logic tap_reset,
  // Serial pins
  input  wire logic tdi,
  output var  logic tdo,
  output var  logic tdo_oe,
  // Port state strobes from the state machine, on tck
  input  wire logic capture_ir,
  input  wire logic shift_ir,
  input  wire logic update_ir,
  input  wire logic capture_dr,
  input  wire logic shift_dr,
  input  wire logic update_dr,
  // Boundary scan chain controls and return path
  input  wire logic boundary_scan_chain_tdo,
  output var  logic boundary_scan_chain_capture,
  output var  logic boundary_scan_chain_shift,
  output var  logic boundary_scan_chain_update,
  output var  logic boundary_scan_chain_drive_pins,
  output var  logic system_outputs_highz,
  // Internal scan register controls and return path
  input  wire logic internal_scan_tdo,
  output var  logic internal_scan_capture,
  output var  logic internal_scan_shift,
  output var  logic internal_scan_update,
  // Programming remap, on tck
  input  wire logic programming_data_out,
  output var  logic programming_data_line,
  output var  logic programming_clock_line,
  output var  logic pin_remap_tck,
  // Device clear, on sys_clk
  input  wire logic master_clear_pin,
  output var  logic device_clear,
  output var  logic pin_remap_active
);

  // Instruction register, decoded selection and mode flags
  logic [`JTID_IR_W-1:0] ir_shift_ff;
  logic [`JTID_IR_W-1:0] ir_ff;
  jtid_sel_type          sel_ff;
  jtid_sel_type          nxt_sel;
  logic                  extest_ff;
  logic                  nxt_extest;
  logic                  highz_ff;
  logic                  nxt_highz;
  // One-stage bypass and identification shift register
  logic                  bypass_ff;
  logic [`JTID_ID_W-1:0] id_ff;
  // Command register outputs
  logic                  cmd_sel;
  logic                  cmd_shift_out;
  logic [`JTID_CMD_W-1:0] cmd;
  logic                  cmd_strobe;
  // Command effects held on tck
  logic                  clear_tog_ff;
  logic                  remap_ff;
  // Serial output registers, falling edge
  logic                  tdo_ff;
  logic                  tdo_oe_ff;
  logic                  serial_bit;
  // System side
  logic                  clear_tog_sys;
  logic                  clear_tog_seen_ff;
  logic                  master_clear_pin_sys;
  logic                  remap_sys;
  logic                  device_clear_ff;
  logic                  remap_active_ff;
  logic [2:0]            settle_ff;
  logic                  settled;

  // Instruction code to data register; unknown codes fall to bypass
  always_comb begin
    nxt_sel    = JTID_SEL_BYPASS;
    nxt_extest = 1'b0;
    nxt_highz  = 1'b0;
    case (ir_shift_ff)
      `JTID_INS_SAMPLE: begin
        nxt_sel = JTID_SEL_BSR; // RQ2
      end
      `JTID_INS_EXTEST: begin
        nxt_sel    = JTID_SEL_BSR; // RQ4
        nxt_extest = 1'b1; // RQ4
      end
      `JTID_INS_IDCODE: begin
        nxt_sel = JTID_SEL_IDCODE; // RQ7
      end
      `JTID_INS_HIGHZ: begin
        nxt_sel   = JTID_SEL_BYPASS; // RQ9
        nxt_highz = 1'b1; // RQ8
      end
      `JTID_INS_ISCAN: begin
        nxt_sel = JTID_SEL_ISCAN; // RQ10
      end
      `JTID_INS_CMD: begin
        nxt_sel = JTID_SEL_CMD; // RQ11
      end
      `JTID_INS_BYPASS: begin
        nxt_sel = JTID_SEL_BYPASS; // RQ15
      end
      default: begin
        nxt_sel = JTID_SEL_BYPASS;
      end
    endcase
  end

  // Instruction shift stages
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      ir_shift_ff <= `JTID_INS_IDCODE;
    end else if (capture_ir) begin
      ir_shift_ff <= `JTID_IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift_ff <= {tdi, ir_shift_ff[`JTID_IR_W-1:1]};
    end
  end

  // Parallel instruction and decoded flags change together at Update-IR
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      ir_ff     <= `JTID_INS_IDCODE;
      sel_ff    <= JTID_SEL_IDCODE;
      extest_ff <= 1'b0;
      highz_ff  <= 1'b0;
    end else if (update_ir) begin
      ir_ff     <= ir_shift_ff;
      sel_ff    <= nxt_sel;
      extest_ff <= nxt_extest; // RQ1
      highz_ff  <= nxt_highz; // RQ8
    end
  end

  // Boundary chain follows the state strobes while it is selected
  assign boundary_scan_chain_capture = (sel_ff == JTID_SEL_BSR) && capture_dr; // RQ16 RQ5
  assign boundary_scan_chain_shift   = (sel_ff == JTID_SEL_BSR) && shift_dr; // RQ2
  assign boundary_scan_chain_update  = (sel_ff == JTID_SEL_BSR) && update_dr;
  // Output cells own the pins only under EXTEST; latch contents as they stand
  assign boundary_scan_chain_drive_pins = extest_ff; // RQ1 RQ3
  assign system_outputs_highz           = highz_ff; // RQ8

  // Internal scan register strobes
  assign internal_scan_capture = (sel_ff == JTID_SEL_ISCAN) && capture_dr; // RQ10
  assign internal_scan_shift   = (sel_ff == JTID_SEL_ISCAN) && shift_dr; // RQ10
  assign internal_scan_update  = (sel_ff == JTID_SEL_ISCAN) && update_dr;

  // One-stage bypass captures zero
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bypass_ff <= 1'b0;
    end else if (sel_ff == JTID_SEL_BYPASS) begin
      if (capture_dr) begin
        bypass_ff <= 1'b0;
      end else if (shift_dr) begin
        bypass_ff <= tdi; // RQ9 RQ15
      end
    end
  end

  // Identification word loads at capture and shifts out low bit first
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      id_ff <= `JTID_ID_VALUE;
    end else if (sel_ff == JTID_SEL_IDCODE) begin
      if (capture_dr) begin
        id_ff <= `JTID_ID_VALUE; // RQ7
      end else if (shift_dr) begin
        id_ff <= {tdi, id_ff[`JTID_ID_W-1:1]}; // RQ7
      end
    end
  end

  // Command shift register and its latch
  assign cmd_sel = (sel_ff == JTID_SEL_CMD);

  jtid_cmd_reg u_cmd (
    .tck        (tck),
    .tap_reset  (tap_reset),
    .tdi        (tdi),
    .selected   (cmd_sel),
    .capture_dr (capture_dr),
    .shift_dr   (shift_dr),
    .update_dr  (update_dr),
    .shift_out  (cmd_shift_out),
    .cmd        (cmd),
    .cmd_strobe (cmd_strobe)
  );

  // Command decode; port state is never touched by the clear
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      clear_tog_ff <= 1'b0;
      remap_ff     <= 1'b0;
    end else if (cmd_strobe) begin
      case (cmd)
        `JTID_CMD_CLEAR: begin
          clear_tog_ff <= ~clear_tog_ff; // RQ13 RQ14
        end
        `JTID_CMD_REMAP: begin
          remap_ff <= 1'b1; // RQ17
        end
        default: begin
          remap_ff <= remap_ff; // RQ12 RQ19
        end
      endcase
    end
  end

  // Remapped pins: data in from the serial input, clock from tck
  assign pin_remap_tck          = remap_ff;
  assign programming_data_line  = remap_ff & tdi; // RQ17
  assign programming_clock_line = remap_ff & tck; // RQ17

  // Serial output source by current state and selection
  always_comb begin
    serial_bit = bypass_ff;
    if (shift_ir) begin
      serial_bit = ir_shift_ff[0];
    end else begin
      case (sel_ff)
        JTID_SEL_BYPASS: begin
          serial_bit = bypass_ff; // RQ9
        end
        JTID_SEL_IDCODE: begin
          serial_bit = id_ff[0]; // RQ7
        end
        JTID_SEL_BSR: begin
          serial_bit = boundary_scan_chain_tdo; // RQ2
        end
        JTID_SEL_ISCAN: begin
          serial_bit = internal_scan_tdo; // RQ10
        end
        JTID_SEL_CMD: begin
          serial_bit = cmd_shift_out; // RQ11
        end
        default: begin
          serial_bit = bypass_ff;
        end
      endcase
    end
  end

  // Serial output changes on the falling edge; remap hands it to programming data
  always_ff @(negedge tck) begin
    if (tap_reset) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (remap_ff) begin
      tdo_ff    <= programming_data_out; // RQ17
      tdo_oe_ff <= 1'b1;
    end else begin
      tdo_ff    <= serial_bit;
      tdo_oe_ff <= shift_ir | shift_dr;
    end
  end

  assign tdo    = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // Crossings into the system domain
  jtid_sync u_sync_clear (
    .clk  (sys_clk),
    .rst  (rst),
    .din  (clear_tog_ff),
    .dout (clear_tog_sys)
  );

  jtid_sync u_sync_remap (
    .clk  (sys_clk),
    .rst  (rst),
    .din  (remap_ff),
    .dout (remap_sys)
  );

  jtid_sync u_sync_master_clear_pin (
    .clk  (sys_clk),
    .rst  (rst),
    .din  (master_clear_pin),
    .dout (master_clear_pin_sys)
  );

  // Settling count after a system reset: the synced toggle may step once to the
  // level already held on tck, which is no command; a clear inside the window is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != `JTID_SYNC_SETTLE) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  // Toggle edges count only once the window has closed
  assign settled = (settle_ff == `JTID_SYNC_SETTLE);

  // Toggle edge becomes a one-cycle clear, merged with the pin clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clear_tog_seen_ff <= 1'b0;
      device_clear_ff   <= 1'b0;
      remap_active_ff   <= 1'b0;
    end else begin
      clear_tog_seen_ff <= clear_tog_sys;
      device_clear_ff   <= ((clear_tog_sys ^ clear_tog_seen_ff) & settled) | master_clear_pin_sys; // RQ13
      remap_active_ff   <= remap_sys;
    end
  end

  assign device_clear     = device_clear_ff;
  assign pin_remap_active = remap_active_ff;

endmodule // jtid_instruction_decode
`default_nettype wire

// ---- verification/jtid_tester.sv ----
// Behavioural boundary-scan tester driving the port strobes
`timescale 1ns/10ps
`default_nettype none
module jtid_tester (
  // Test clock and serial return
  input  wire logic       tck,
  input  wire logic       tdo,
  // Port reset, serial data, strobes {cir,sir,uir,cdr,sdr,udr}
  output var  logic       tap_reset,
  output var  logic       tdi,
  output var  logic [5:0] st
);
  // Hold the port in reset until the bench releases it
  initial begin
    tap_reset = 1'b1;
    tdi = 1'b0;
    st = 6'h00;
  end
  // One tck cycle; outside shifts tdi toggles so no stale bit lingers
  task automatic step(input logic [5:0] s, input logic b, output logic q);
    st <= s;
    tdi <= (s[4] | s[1]) ? b : ~tdi;
    @(posedge tck);
    q = tdo;
  endtask
  // Capture, shift n bits lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    @(posedge tck);
    step(ir ? 6'h20 : 6'h04, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(ir ? 6'h10 : 6'h02, din[i], q);
      dout[i] = q;
    end
    step(ir ? 6'h08 : 6'h01, 1'b0, q);
    step(6'h00, 1'b0, q);
  endtask
  // Port reset held for two tck edges
  task automatic reset_port();
    @(posedge tck);
    tap_reset <= 1'b1;
    st <= 6'h00;
    repeat (2) @(posedge tck);
    tap_reset <= 1'b0;
    @(posedge tck);
  endtask
endmodule // jtid_tester
`default_nettype wire

// ---- verification/jtid_decode_assertions.sv ----
// Concurrent checks on the test port decode block
`timescale 1ns/10ps
`default_nettype none
module jtid_decode_checker (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tap_reset,
  // Port strobes and output enable
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic tdo_oe,
  // Selection and modes
  input wire logic boundary_scan_chain_shift,
  input wire logic boundary_scan_chain_drive_pins,
  input wire logic system_outputs_highz,
  input wire logic internal_scan_shift,
  // Remap and clear
  input wire logic pin_remap_tck,
  input wire logic master_clear_pin,
  input wire logic device_clear,
  input wire logic pin_remap_active
);
  // Pin low long enough for its synced copy to be gone
  sequence s_pin_quiet;
    (!master_clear_pin) [*8];
  endsequence
  // Remap held longer than the crossing takes
  sequence s_remap_steady;
    pin_remap_tck [*8];
  endsequence
  property p_chain_shift;
    @(posedge tck) disable iff (tap_reset) boundary_scan_chain_shift |-> shift_dr;
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("chain shift off state");
  property p_path_excl;
    @(posedge tck) disable iff (tap_reset) !(boundary_scan_chain_shift && internal_scan_shift);
  endproperty
  a_path_excl: assert property (p_path_excl) else $error("two paths shifting");
  property p_pins_cause;
    @(posedge tck) disable iff (tap_reset)
      !$stable(boundary_scan_chain_drive_pins) |-> $past(update_ir);
  endproperty
  a_pins_cause: assert property (p_pins_cause) else $error("drive pins moved alone");
  property p_highz_cause;
    @(posedge tck) disable iff (tap_reset) !$stable(system_outputs_highz) |-> $past(update_ir);
  endproperty
  a_highz_cause: assert property (p_highz_cause) else $error("highz moved alone");
  property p_oe_shift;
    @(posedge tck) disable iff (tap_reset) (shift_dr || shift_ir) |-> tdo_oe;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo not driven in shift");
  property p_remap_cause;
    @(posedge tck) disable iff (tap_reset)
      $rose(pin_remap_tck) |-> $past(update_dr, 2) || $past(update_dr, 3);
  endproperty
  a_remap_cause: assert property (p_remap_cause) else $error("remap without update");
  property p_remap_hold;
    @(posedge tck) disable iff (tap_reset) pin_remap_tck |=> pin_remap_tck;
  endproperty
  a_remap_hold: assert property (p_remap_hold) else $error("remap dropped");
  property p_remap_sync;
    @(posedge sys_clk) disable iff (rst) s_remap_steady |-> ##[0:4] pin_remap_active;
  endproperty
  a_remap_sync: assert property (p_remap_sync) else $error("remap not crossed");
  property p_clear_pulse;
    @(posedge sys_clk) disable iff (rst) s_pin_quiet ##0 device_clear |=> !device_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");
endmodule // jtid_decode_checker
bind jtid_instruction_decode jtid_decode_checker u_chk (.*);
`default_nettype wire

// ---- verification/test_jtag_instruction_decode.sv ----
// Self-checking bench for the test port decode block
`timescale 1ns/10ps
`default_nettype none
`include "jtid_defines.svh"
`define JTID_CHK(what, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); \
  end \
end
module test_jtag_instruction_decode;
  // Clocks, resets and side inputs
  logic        sys_clk = 1'b0;
  logic        tck = 1'b0;
  logic        rst = 1'b1;
  logic        master_clear_pin = 1'b0;
  logic        boundary_scan_chain_tdo = 1'b1;
  logic        internal_scan_tdo = 1'b1;
  logic        programming_data_out = 1'b0;
  // Tester side
  logic        tap_reset, tdi;
  logic [5:0]  st;
  logic        capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr;
  // Block outputs
  logic        tdo, tdo_oe, internal_scan_capture, internal_scan_shift, internal_scan_update;
  logic        boundary_scan_chain_capture, boundary_scan_chain_shift;
  logic        boundary_scan_chain_update, boundary_scan_chain_drive_pins;
  logic        system_outputs_highz, programming_data_line, programming_clock_line;
  logic        pin_remap_tck, device_clear, pin_remap_active;
  // Bench state
  int          errors = 0;
  int          n_checks = 0;
  int          n;
  logic        q;
  logic [31:0] dout;
  // Rows: instruction, drive pins, highz, chain shift, internal shift
  logic [7:0]  rows [8] = '{8'h12, 8'h3A, 8'h20, 8'h44, 8'h71, 8'h80, 8'hF0, 8'h50};
  logic [15:0] cmd_val [3] = '{16'h0000, 16'hA501, 16'h0001};

  assign {capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr} = st;
  // System clock and unrelated test clock
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #7.5 tck = ~tck;
  end
  jtid_instruction_decode u_dut (.*);
  jtid_tester u_tst (.tck(tck), .tdo(tdo), .tap_reset(tap_reset), .tdi(tdi), .st(st));

  // Count cycles with the clear output high
  task automatic count_clear();
    n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (device_clear === 1'b1) n++;
    end
  endtask
  // Print counts and verdict, then stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    u_tst.reset_port();
    // Port reset leaves the identification word selected
    u_tst.scan(1'b0, 32, 32'h0000_0000, dout);
    `JTID_CHK("id word", `JTID_ID_VALUE, dout)
    $display("id test done");
    // Each instruction: modes and path; preload comes before the stimulus instruction
    for (int r = 0; r < 8; r++) begin
      u_tst.scan(1'b1, 4, {28'h000_0000, rows[r][7:4]}, dout);
      `JTID_CHK("drive pins", rows[r][3], boundary_scan_chain_drive_pins)
      `JTID_CHK("highz", rows[r][2], system_outputs_highz)
      u_tst.step(6'h04, 1'b0, q);
      `JTID_CHK("chain capture", rows[r][1], boundary_scan_chain_capture)
      `JTID_CHK("internal capture", rows[r][0], internal_scan_capture)
      u_tst.step(6'h02, 1'b0, q);
      `JTID_CHK("chain shift", rows[r][1], boundary_scan_chain_shift)
      `JTID_CHK("internal shift", rows[r][0], internal_scan_shift)
      `JTID_CHK("first bit", rows[r][1] | rows[r][0] | (rows[r][7:4] == 4'h2), q)
      u_tst.step(6'h01, 1'b0, q);
      `JTID_CHK("chain update", rows[r][1], boundary_scan_chain_update)
      `JTID_CHK("internal update", rows[r][0], internal_scan_update)
      u_tst.step(6'h00, 1'b0, q);
      $display("row %0d done", r);
    end
    // Reserved code, clear pattern shifted past, then clear
    for (int i = 0; i < 3; i++) begin
      u_tst.scan(1'b1, 4, 32'h0000_0008, dout);
      u_tst.scan(1'b0, (i == 1) ? 16 : 8, {16'h0000, cmd_val[i]}, dout);
      count_clear();
      `JTID_CHK("clear cycles", (i == 2) ? 1 : 0, n)
      $display("command %0d done", i);
    end
    // Command path and latch survive the clear
    u_tst.scan(1'b0, 8, 32'h0000_0000, dout);
    `JTID_CHK("latched command", 8'h01, dout[7:0])
    // External clear pin gives a level
    @(negedge sys_clk);
    master_clear_pin = 1'b1;
    repeat (10) @(negedge sys_clk);
    `JTID_CHK("clear level", 1'b1, device_clear)
    master_clear_pin = 1'b0;
    repeat (10) @(negedge sys_clk);
    `JTID_CHK("clear off", 1'b0, device_clear)
    $display("clear test done");
    // Remap command turns the pins over to programming
    u_tst.scan(1'b0, 8, 32'h0000_0002, dout);
    for (n = 0; n < 40 && pin_remap_active !== 1'b1; n++) @(negedge sys_clk);
    `JTID_CHK("remap active", 1'b1, pin_remap_active)
    if (n == 40) conclude();
    for (int v = 0; v < 2; v++) begin
      @(negedge sys_clk);
      programming_data_out = v[0];
      @(posedge tck);
      u_tst.step(6'h00, 1'b0, q);
      #2;
      `JTID_CHK("remap tdo", v[0], q)
      `JTID_CHK("remap oe", 1'b1, tdo_oe)
      `JTID_CHK("remap data", tdi, programming_data_line)
      `JTID_CHK("remap clock", tck, programming_clock_line)
      @(negedge tck);
      #2;
      `JTID_CHK("remap clock low", 1'b0, programming_clock_line)
    end
    // System reset mid-run drops the synced flag only
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    `JTID_CHK("remap in reset", 1'b0, pin_remap_active)
    `JTID_CHK("remap kept", 1'b1, pin_remap_tck)
    rst = 1'b0;
    count_clear();
    `JTID_CHK("clear after reset", 0, n)
    u_tst.reset_port();
    `JTID_CHK("remap after port reset", 1'b0, pin_remap_tck)
    $display("remap test done");
    conclude();
  end
endmodule // test_jtag_instruction_decode
`default_nettype wire
